/* hw/nac_pkg.sv */
// ============================================================
// shared constants for the nested accept controller
package nac_pkg;

  // ============================================================
  // sizes
  localparam int NAC_SRC_N = 8;
  localparam int NAC_ID_W = 3;
  localparam int NAC_ADDR_W = 5;
  localparam int NAC_DATA_W = 32;
  localparam int NAC_VEC_W = 16;

  // ============================================================
  // register byte offsets
  localparam logic [NAC_ADDR_W-1:0] NAC_OFF_REQUEST = 5'h00;
  localparam logic [NAC_ADDR_W-1:0] NAC_OFF_MASK = 5'h04;
  localparam logic [NAC_ADDR_W-1:0] NAC_OFF_LEVEL = 5'h08;
  localparam logic [NAC_ADDR_W-1:0] NAC_OFF_STATUS = 5'h0C;

  // ============================================================
  // reset values
  localparam logic [NAC_SRC_N-1:0] NAC_RST_REQUEST = 8'h00;
  localparam logic [NAC_SRC_N-1:0] NAC_RST_MASK = 8'hFF;
  localparam logic [NAC_SRC_N-1:0] NAC_RST_LEVEL = 8'hFF;
  localparam logic NAC_RST_ACCEPT = 1'b0;
  localparam logic NAC_RST_SERVICED = 1'b1;

  // ============================================================
  // status word bit positions and vectors
  localparam int NAC_PSW_ACCEPT_BIT = 7;
  localparam int NAC_PSW_LEVEL_BIT = 1;
  localparam int NAC_STAT_ACCEPT_BIT = 0;
  localparam int NAC_STAT_LEVEL_BIT = 1;
  localparam int NAC_STAT_BUSY_BIT = 2;
  localparam int NAC_STAT_HOLD_BIT = 3;
  localparam logic [NAC_VEC_W-1:0] NAC_TRAP_VECTOR = 16'h003E;
  localparam logic [NAC_VEC_W-1:0] NAC_VEC_BASE_DEF = 16'h0004;

  // ============================================================
  // bus responses
  localparam logic [1:0] NAC_RESP_OKAY = 2'b00;
  localparam logic [1:0] NAC_RESP_SLVERR = 2'b10;

  // ============================================================
  // instruction kinds reported by the sequencer at each boundary
  typedef enum logic [2:0] {
    NAC_K_NORMAL = 3'h0,
    NAC_K_TRAP = 3'h1,
    NAC_K_SET_ACCEPT = 3'h2,
    NAC_K_CLEAR_ACCEPT = 3'h3,
    NAC_K_VEC_RETURN = 3'h4,
    NAC_K_TRAP_RETURN = 3'h5,
    NAC_K_PSW_WRITE = 3'h6,
    NAC_K_PSW_HOLD = 3'h7
  } nac_kind_t;

  // ============================================================
  // entry and return sequencer states
  typedef enum logic [6:0] {
    NAC_ST_IDLE = 7'b000_0001,
    NAC_ST_PUSH_PSW = 7'b000_0010,
    NAC_ST_PUSH_PTR = 7'b000_0100,
    NAC_ST_LOAD_VEC = 7'b000_1000,
    NAC_ST_POP_PTR = 7'b001_0000,
    NAC_ST_POP_PSW = 7'b010_0000,
    NAC_ST_POP_WAIT = 7'b100_0000
  } nac_state_t;

endpackage

/* hw/nac_pick.sv */
`timescale 1ns/10ps
// ============================================================
// picks the winning pending source: programmable level first,
// then fixed default order (lowest index wins)
module nac_pick #(
  parameter int N = 8,
  parameter int IW = 3
) (
  // candidates
  input wire logic [N-1:0] eligible,
  input wire logic [N-1:0] level,
  // winner
  output logic found,
  output logic [IW-1:0] id,
  output logic lvl
);

  // high level pass, then low level pass; later hits overwrite earlier
  always_comb begin
    found = 1'b0;
    id = '0;
    lvl = 1'b1;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i] && !level[i]) begin
        found = 1'b1;
        id = IW'(i);
        lvl = 1'b0;
      end
    end
    if (!found) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          found = 1'b1;
          id = IW'(i);
          lvl = 1'b1;
        end
      end
    end
  end

endmodule // nac_pick

/* hw/nac_ctrl.sv */
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// What this block does
// - a soft trap instruction is always taken; no flag or mask blocks it
// - trap entry pushes status word, then pointer, clears accept, loads fixed vector
// - soft trap return ends a trap; software must not use vectored return there
// - no maskable request is accepted while the global accept flag is clear
// - every acceptance clears the global accept flag
// - set-accept instruction sets the flag; handlers use it to allow nesting
// - with accept set, equal or higher level nests, lower level is refused
// - refused requests stay pending, taken after one main instruction past return
// - high level in service: only high level requests nest, accept set
// - low or no level in service, or trap service: both levels nest
// - level select bit 0 means high level, 1 means low level
// - a soft trap is accepted in every servicing state
// - status word and return instructions defer acceptance one instruction
// - writes to request, mask or level registers defer acceptance likewise
// - soft trap does not defer, but its flag clear blocks maskable acceptance
// - request flags capture events whatever the level select value
// - fixed default order plus two programmable levels decide nesting
// - a request is acceptable only with request flag 1 and mask flag 0
// - maskable entry copies the source level into the serviced flag after pushes
module nac_ctrl
  import nac_pkg::*;
#(
  parameter logic [NAC_VEC_W-1:0] VEC_BASE = NAC_VEC_BASE_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // axi4-lite write address and data
  input wire logic [NAC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [NAC_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [NAC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [NAC_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // peripheral request events, one-cycle pulses on this clock
  input wire logic [NAC_SRC_N-1:0] src_event,
  // instruction sequencer
  input wire logic instr_done,
  input wire nac_kind_t instr_kind,
  input wire logic [7:0] psw_wr_data,
  input wire logic pop_valid,
  input wire logic [7:0] pop_data,
  // status word flags and stack control
  output logic global_accept_flag,
  output logic serviced_level_flag,
  output logic seq_busy,
  output logic push_strobe,
  output logic push_sel_ptr,
  output logic pop_strobe,
  output logic pop_sel_ptr,
  output logic vec_load,
  output logic [NAC_VEC_W-1:0] vec_addr
);

  // ============================================================
  // registers
  logic [NAC_SRC_N-1:0] request_flag;
  logic [NAC_SRC_N-1:0] mask_flag;
  logic [NAC_SRC_N-1:0] level_select_flag;
  logic bank_hold;
  nac_state_t state;
  logic pend_level;
  logic [NAC_VEC_W-1:0] pend_vec;

  // ============================================================
  // arbitration
  wire [NAC_SRC_N-1:0] eligible = request_flag & ~mask_flag;
  logic pick_found;
  logic [NAC_ID_W-1:0] pick_id;
  logic pick_level;

  // level bits steer the pick, default order breaks ties
  nac_pick #(
    .N(NAC_SRC_N),
    .IW(NAC_ID_W)
  ) u_pick (
    .eligible(eligible),
    .level(level_select_flag),
    .found(pick_found),
    .id(pick_id),
    .lvl(pick_level)
  );

  // ============================================================
  // instruction boundary decode
  wire idle = (state == NAC_ST_IDLE);
  wire boundary = instr_done && idle;
  wire kind_trap = (instr_kind == NAC_K_TRAP);
  wire kind_ret = (instr_kind == NAC_K_VEC_RETURN) || (instr_kind == NAC_K_TRAP_RETURN);
  // status word touchers, flag instructions and returns hold acceptance
  wire kind_hold = (instr_kind == NAC_K_SET_ACCEPT) || (instr_kind == NAC_K_CLEAR_ACCEPT) ||
                   (instr_kind == NAC_K_PSW_WRITE) || (instr_kind == NAC_K_PSW_HOLD) || kind_ret;
  // trap needs no flag and works in any service state
  wire do_trap = boundary && kind_trap;
  // nesting test: accept flag first, then level against serviced flag
  wire level_ok = serviced_level_flag || !pick_level;
  wire can_nest = global_accept_flag && pick_found && level_ok;
  // trap boundary itself never takes a maskable request
  wire do_mask = boundary && !kind_trap && !kind_hold && !bank_hold && can_nest;
  // both returns share the pop sequence; misuse is left to software
  wire do_ret = boundary && kind_ret;
  wire do_set = boundary && (instr_kind == NAC_K_SET_ACCEPT);
  wire do_clr = boundary && (instr_kind == NAC_K_CLEAR_ACCEPT);
  wire do_pswr = boundary && (instr_kind == NAC_K_PSW_WRITE);
  wire restore = (state == NAC_ST_POP_WAIT) && pop_valid;

  // ============================================================
  // sequencer next state
  nac_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      NAC_ST_IDLE: begin
        if (do_trap || do_mask) begin
          next_state = NAC_ST_PUSH_PSW;
        end else if (do_ret) begin
          next_state = NAC_ST_POP_PTR;
        end
      end
      NAC_ST_PUSH_PSW: next_state = NAC_ST_PUSH_PTR;
      NAC_ST_PUSH_PTR: next_state = NAC_ST_LOAD_VEC;
      NAC_ST_LOAD_VEC: next_state = NAC_ST_IDLE;
      NAC_ST_POP_PTR: next_state = NAC_ST_POP_PSW;
      NAC_ST_POP_PSW: next_state = NAC_ST_POP_WAIT;
      NAC_ST_POP_WAIT: begin
        if (pop_valid) begin
          next_state = NAC_ST_IDLE;
        end
      end
      default: next_state = NAC_ST_IDLE;
    endcase
  end

  // ============================================================
  // flag updates; entry wins over any restore, they cannot coincide anyway
  wire clear_accept_now = (state == NAC_ST_PUSH_PTR); // cleared once the status word is saved
  wire next_accept = clear_accept_now ? 1'b0 :
                     restore ? pop_data[NAC_PSW_ACCEPT_BIT] :
                     do_set ? 1'b1 :
                     do_clr ? 1'b0 :
                     do_pswr ? psw_wr_data[NAC_PSW_ACCEPT_BIT] :
                     global_accept_flag;
  // serviced flag takes the taken level after both pushes
  wire next_level = (state == NAC_ST_LOAD_VEC) ? pend_level :
                    restore ? pop_data[NAC_PSW_LEVEL_BIT] :
                    do_pswr ? psw_wr_data[NAC_PSW_LEVEL_BIT] :
                    serviced_level_flag;
  // trap service counts as low level so both levels may nest
  wire next_pend_level = do_trap ? 1'b1 : pick_level;
  wire [NAC_VEC_W-1:0] mask_vec = VEC_BASE + NAC_VEC_W'({pick_id, 1'b0});
  wire [NAC_VEC_W-1:0] next_pend_vec = do_trap ? NAC_TRAP_VECTOR : mask_vec;

  // ============================================================
  // bus decode
  wire aw_take = awvalid && wvalid && !awready && !bvalid;
  wire wr_en = awready && awvalid && wready && wvalid;
  wire ar_take = arvalid && !arready && !rvalid;
  wire rd_en = arready && arvalid;
  wire lane0 = wstrb[0];
  wire wr_req = wr_en && lane0 && (awaddr == NAC_OFF_REQUEST);
  wire wr_mask = wr_en && lane0 && (awaddr == NAC_OFF_MASK);
  wire wr_level = wr_en && lane0 && (awaddr == NAC_OFF_LEVEL);
  wire wr_hit = (awaddr == NAC_OFF_REQUEST) || (awaddr == NAC_OFF_MASK) ||
                (awaddr == NAC_OFF_LEVEL) || (awaddr == NAC_OFF_STATUS);
  wire rd_hit = (araddr == NAC_OFF_REQUEST) || (araddr == NAC_OFF_MASK) ||
                (araddr == NAC_OFF_LEVEL) || (araddr == NAC_OFF_STATUS);
  wire [NAC_SRC_N-1:0] wr_byte = wdata[NAC_SRC_N-1:0];

  // request bits: software write, acknowledge clear, event set wins last
  wire [NAC_SRC_N-1:0] ack_clear = do_mask ? (NAC_SRC_N'(1) << pick_id) : '0;
  wire [NAC_SRC_N-1:0] req_base = wr_req ? wr_byte : request_flag;
  wire [NAC_SRC_N-1:0] next_request = (req_base & ~ack_clear) | src_event;
  // bank writes hold acceptance to the end of the next instruction
  wire bank_wr = wr_req || wr_mask || wr_level;
  wire next_bank_hold = bank_wr || (bank_hold && !boundary);

  // status word for software: flags, sequencer busy, pending hold
  logic [NAC_DATA_W-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[NAC_STAT_ACCEPT_BIT] = global_accept_flag;
    status_word[NAC_STAT_LEVEL_BIT] = serviced_level_flag;
    status_word[NAC_STAT_BUSY_BIT] = !idle;
    status_word[NAC_STAT_HOLD_BIT] = bank_hold;
  end

  // read mux; unmapped reads return zero with an error response
  wire [NAC_DATA_W-1:0] rd_mux =
    (araddr == NAC_OFF_REQUEST) ? NAC_DATA_W'(request_flag) :
    (araddr == NAC_OFF_MASK) ? NAC_DATA_W'(mask_flag) :
    (araddr == NAC_OFF_LEVEL) ? NAC_DATA_W'(level_select_flag) :
    (araddr == NAC_OFF_STATUS) ? status_word : '0;

  // ============================================================
  // control state and flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= NAC_ST_IDLE;
      global_accept_flag <= NAC_RST_ACCEPT;
      serviced_level_flag <= NAC_RST_SERVICED;
      pend_level <= NAC_RST_SERVICED;
      pend_vec <= NAC_TRAP_VECTOR;
      bank_hold <= 1'b0;
    end else begin
      state <= next_state;
      global_accept_flag <= next_accept;
      serviced_level_flag <= next_level;
      bank_hold <= next_bank_hold;
      if (do_trap || do_mask) begin
        pend_level <= next_pend_level;
        pend_vec <= next_pend_vec;
      end
    end
  end

  // ============================================================
  // software visible banks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      request_flag <= NAC_RST_REQUEST;
      mask_flag <= NAC_RST_MASK;
      level_select_flag <= NAC_RST_LEVEL;
    end else begin
      request_flag <= next_request; // pending requests stay until taken or rewritten by software
      if (wr_mask) begin
        mask_flag <= wr_byte;
      end
      if (wr_level) begin
        level_select_flag <= wr_byte;
      end
    end
  end

  // ============================================================
  // stack and vector strobes, registered so the core sees clean pulses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq_busy <= 1'b0;
      push_strobe <= 1'b0;
      push_sel_ptr <= 1'b0;
      pop_strobe <= 1'b0;
      pop_sel_ptr <= 1'b0;
      vec_load <= 1'b0;
      vec_addr <= NAC_TRAP_VECTOR;
    end else begin
      seq_busy <= (next_state != NAC_ST_IDLE);
      push_strobe <= (state == NAC_ST_PUSH_PSW) || (state == NAC_ST_PUSH_PTR);
      push_sel_ptr <= (state == NAC_ST_PUSH_PTR);
      pop_strobe <= (state == NAC_ST_POP_PTR) || (state == NAC_ST_POP_PSW);
      pop_sel_ptr <= (state == NAC_ST_POP_PTR);
      vec_load <= (state == NAC_ST_LOAD_VEC);
      if (state == NAC_ST_LOAD_VEC) begin
        vec_addr <= pend_vec;
      end
    end
  end

  // ============================================================
  // axi4-lite write channel: one write at a time, both beats together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= NAC_RESP_OKAY;
    end else begin
      awready <= aw_take;
      wready <= aw_take;
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? NAC_RESP_OKAY : NAC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // axi4-lite read channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= NAC_RESP_OKAY;
    end else begin
      arready <= ar_take;
      if (rd_en) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? NAC_RESP_OKAY : NAC_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // nac_ctrl

/* verification/nac_stack_model.sv */
`timescale 1ns/10ps
// ============================================================
// core stack model: saves status words, answers pops soon or late
module nac_stack_model
  import nac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // stack requests
  input wire logic push_strobe,
  input wire logic push_sel_ptr,
  input wire logic pop_strobe,
  input wire logic pop_sel_ptr,
  input wire logic global_accept_flag,
  input wire logic serviced_level_flag,
  // popped status word
  output logic pop_valid,
  output logic [7:0] pop_data
);
  logic [7:0] stack_mem [8];
  logic [2:0] depth;
  logic [1:0] wait_cnt;
  logic slow;
  wire logic [7:0] psw_now = {global_accept_flag, 5'h00, serviced_level_flag, 1'b0};
  // pointer words carry no flags, so only status words are kept;
  // data toggles while not valid so a stale value never looks right
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      depth <= 3'h0;
      wait_cnt <= 2'h0;
      slow <= 1'b0;
      pop_valid <= 1'b0;
      pop_data <= 8'h00;
    end else begin
      pop_valid <= 1'b0;
      pop_data <= ~pop_data;
      if (push_strobe && !push_sel_ptr) begin
        stack_mem[depth] <= psw_now;
        depth <= depth + 3'h1;
      end
      if (pop_strobe && !pop_sel_ptr) begin
        wait_cnt <= slow ? 2'h3 : 2'h1;
        slow <= !slow;
      end else if (wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
      if (wait_cnt == 2'h1) begin
        pop_valid <= 1'b1;
        pop_data <= stack_mem[depth - 3'h1];
        depth <= depth - 3'h1;
      end
    end
  end
endmodule // nac_stack_model

/* verification/nac_ctrl_assertions.sv */
`timescale 1ns/10ps
// ============================================================
// sequencing checks at the controller ports
module nac_ctrl_assertions
  import nac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // sequencer side
  input wire logic instr_done,
  input wire nac_kind_t instr_kind,
  input wire logic pop_valid,
  input wire logic [7:0] pop_data,
  // controller outputs
  input wire logic global_accept_flag,
  input wire logic serviced_level_flag,
  input wire logic seq_busy,
  input wire logic push_strobe,
  input wire logic push_sel_ptr,
  input wire logic pop_strobe,
  input wire logic pop_sel_ptr,
  input wire logic vec_load,
  input wire logic [NAC_VEC_W-1:0] vec_addr,
  // write response
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // a boundary the controller looks at
  wire logic taken = instr_done && !seq_busy;
  property p_trap_entry;
    taken && instr_kind == NAC_K_TRAP |-> ##2 push_strobe && !push_sel_ptr
      ##1 push_strobe && push_sel_ptr ##1 vec_load && vec_addr == NAC_TRAP_VECTOR;
  endproperty
  a_trap_entry: assert property (p_trap_entry)
    else $error("trap entry sequence wrong");
  property p_entry_busy;
    push_strobe && !push_sel_ptr |-> seq_busy [*2] ##1 !seq_busy;
  endproperty
  a_entry_busy: assert property (p_entry_busy)
    else $error("busy dropped during entry");
  property p_accept_clear;
    vec_load |-> !global_accept_flag;
  endproperty
  a_accept_clear: assert property (p_accept_clear)
    else $error("accept flag set at vector load");
  property p_closed;
    taken && instr_kind == NAC_K_NORMAL && !global_accept_flag |-> ##2 !push_strobe;
  endproperty
  a_closed: assert property (p_closed)
    else $error("entry with accept flag clear");
  property p_hold;
    taken && instr_kind inside {NAC_K_SET_ACCEPT, NAC_K_CLEAR_ACCEPT, NAC_K_PSW_WRITE,
      NAC_K_PSW_HOLD} |-> ##2 !push_strobe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("entry after a hold instruction");
  property p_trap_level;
    vec_load && vec_addr == NAC_TRAP_VECTOR |-> serviced_level_flag;
  endproperty
  a_trap_level: assert property (p_trap_level)
    else $error("trap service left high level set");
  property p_pop_order;
    taken && instr_kind inside {NAC_K_VEC_RETURN, NAC_K_TRAP_RETURN}
      |-> ##2 pop_strobe && pop_sel_ptr ##1 pop_strobe && !pop_sel_ptr;
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("return pop order wrong");
  property p_restore;
    seq_busy && pop_valid |=> global_accept_flag == $past(pop_data[NAC_PSW_ACCEPT_BIT])
      && serviced_level_flag == $past(pop_data[NAC_PSW_LEVEL_BIT]);
  endproperty
  a_restore: assert property (p_restore)
    else $error("flags not restored from popped word");
  property p_resp_stands;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_resp_stands: assert property (p_resp_stands)
    else $error("write response dropped early");
endmodule // nac_ctrl_assertions

bind nac_ctrl nac_ctrl_assertions u_chk (.clock, .rst_b, .instr_done, .instr_kind,
  .pop_valid, .pop_data, .global_accept_flag, .serviced_level_flag, .seq_busy,
  .push_strobe, .push_sel_ptr, .pop_strobe, .pop_sel_ptr, .vec_load, .vec_addr,
  .bresp, .bvalid, .bready);

/* verification/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import nac_pkg::*;
  // ============================================================
  // signals
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, e, pop_valid;
  logic [1:0] bresp, rresp, r;
  logic [7:0] src_event = '0, psw_wr_data = 8'h82, pop_data, lv;
  logic instr_done = 0;
  nac_kind_t instr_kind = NAC_K_NORMAL;
  logic acc, lvl, busy, push_s, push_p, pop_s, pop_p, vec_load;
  logic [15:0] vec_addr;
  int num_errors = 0, checks_done = 0, s, a, b, seed;
  nac_kind_t hk [3] = '{NAC_K_PSW_WRITE, NAC_K_PSW_HOLD, NAC_K_CLEAR_ACCEPT};
  always #20 clock = ~clock;
  // ============================================================
  // design and core model
  nac_ctrl uut (.clock, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .src_event, .instr_done, .instr_kind, .psw_wr_data, .pop_valid, .pop_data,
    .global_accept_flag(acc), .serviced_level_flag(lvl), .seq_busy(busy),
    .push_strobe(push_s), .push_sel_ptr(push_p), .pop_strobe(pop_s), .pop_sel_ptr(pop_p),
    .vec_load, .vec_addr);
  nac_stack_model u_stack (.clock, .rst_b, .push_strobe(push_s), .push_sel_ptr(push_p),
    .pop_strobe(pop_s), .pop_sel_ptr(pop_p), .global_accept_flag(acc),
    .serviced_level_flag(lvl), .pop_valid, .pop_data);
  // ============================================================
  // expectations
  function automatic logic nest_ok(input logic sl, input logic rl);
    return !(sl == 1'b0 && rl == 1'b1); // a low request may not cut into high service
  endfunction
  function automatic logic [15:0] vec_of(input int id);
    return NAC_VEC_BASE_DEF + 16'(2 * id);
  endfunction
  function automatic logic [31:0] rst_val(input int i);
    logic [31:0] st;
    st = '0;
    st[NAC_STAT_ACCEPT_BIT] = NAC_RST_ACCEPT;
    st[NAC_STAT_LEVEL_BIT] = NAC_RST_SERVICED;
    case (i)
      0: return 32'(NAC_RST_REQUEST);
      1: return 32'(NAC_RST_MASK);
      2: return 32'(NAC_RST_LEVEL);
      default: return st;
    endcase
  endfunction
  // ============================================================
  // drivers; every wait is bounded
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 60) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, dt, 3'b111};
    do tick(n); while (awready !== 1'b1);
    {awvalid, wvalid} <= 2'b00;
    do tick(n); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clock);
    {araddr, arvalid, rready} <= {ad, 2'b11};
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    {dt, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic pulse(input int id);
    @(posedge clock);
    src_event <= 8'h01 << id;
    @(posedge clock);
    src_event <= 8'h00;
  endtask
  // one instruction boundary; reports whether a sequence started
  task automatic step(input nac_kind_t k, output logic started);
    int n;
    n = 0;
    @(posedge clock);
    {instr_done, instr_kind} <= {1'b1, k};
    @(posedge clock);
    instr_done <= 1'b0;
    #1 started = busy;
    while (busy !== 1'b0) tick(n);
  endtask
  // ============================================================
  // main sequence
  initial begin
    seed = $urandom(32'hb0b1_3d50);
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    `CHK(vec_addr, NAC_TRAP_VECTOR)
    for (int i = 0; i < 4; i++) begin
      axi_rd(5'(4 * i), d, r);
      `CHK(d, rst_val(i))
    end
    axi_rd(5'h10, d, r);
    `CHK(r, NAC_RESP_SLVERR)
    axi_wr(5'h12, 32'h0000_0000, r);
    `CHK(r, NAC_RESP_SLVERR)
    // hold instructions, mask and closed flag all refuse a pending source
    s = $urandom % 8;
    lv = 8'($urandom);
    axi_wr(NAC_OFF_LEVEL, 32'(lv), r);
    pulse(s);
    axi_rd(NAC_OFF_REQUEST, d, r);
    `CHK(d[s], 1'b1)
    step(NAC_K_SET_ACCEPT, e);
    `CHK(acc, 1'b1)
    step(NAC_K_NORMAL, e);
    `CHK(e, 1'b0)
    axi_wr(NAC_OFF_MASK, 32'(~(8'h01 << s)), r);
    axi_rd(NAC_OFF_STATUS, d, r);
    `CHK(d[NAC_STAT_HOLD_BIT], 1'b1)
    step(NAC_K_NORMAL, e);
    `CHK(e, 1'b0)
    foreach (hk[i]) begin
      step(hk[i], e);
      `CHK(e, 1'b0)
    end
    step(NAC_K_NORMAL, e);
    `CHK(e, 1'b0)
    step(NAC_K_SET_ACCEPT, e);
    step(NAC_K_NORMAL, e);
    `CHK({e, acc, lvl, vec_addr}, {2'b10, lv[s], vec_of(s)})
    axi_rd(NAC_OFF_REQUEST, d, r);
    `CHK(d[s], 1'b0)
    // trap inside maskable service, flags closed
    step(NAC_K_TRAP, e);
    `CHK({e, acc, lvl, vec_addr}, {3'b101, NAC_TRAP_VECTOR})
    pulse(s);
    step(NAC_K_NORMAL, e);
    `CHK(e, 1'b0)
    step(NAC_K_TRAP_RETURN, e);
    `CHK(lvl, lv[s])
    step(NAC_K_VEC_RETURN, e);
    `CHK({acc, lvl}, 2'b11)
    step(NAC_K_NORMAL, e);
    step(NAC_K_VEC_RETURN, e);
    // nesting across every pair of levels with random sources
    for (int i = 0; i < 4; i++) begin
      a = $urandom % 8;
      b = (a + 1 + $urandom % 7) % 8;
      lv = 8'($urandom);
      lv[a] = i[1];
      lv[b] = i[0];
      axi_wr(NAC_OFF_LEVEL, 32'(lv), r);
      axi_wr(NAC_OFF_MASK, 32'(~((8'h01 << a) | (8'h01 << b))), r);
      pulse(a);
      step(NAC_K_SET_ACCEPT, e);
      step(NAC_K_NORMAL, e);
      `CHK({e, vec_addr}, {1'b1, vec_of(a)})
      step(NAC_K_SET_ACCEPT, e);
      pulse(b);
      step(NAC_K_NORMAL, e);
      `CHK(e, nest_ok(i[1], i[0]))
      if (e) step(NAC_K_VEC_RETURN, e);
      step(NAC_K_VEC_RETURN, e);
      if (!nest_ok(i[1], i[0])) begin
        step(NAC_K_NORMAL, e);
        `CHK({e, vec_addr}, {1'b1, vec_of(b)})
        step(NAC_K_VEC_RETURN, e);
      end
    end
    report_and_stop();
  end
endmodule // tb
